//--- design/rsom_top.sv
// ratio select, fractional-n source select and output muxing with wishbone registers
//
// Notes on behaviour
// - modifier scales selected ratio, stored ratios unchanged
// - effective ratio is ratio times modifier, then shifted for the divider
// - modifier codes 1..8 then 0.5..0.0625
// - effective ratio compensated for reference divider
// - static pointer selects; lock pointer in auto while dynamic
// - source is effective ratio or dpll ratio
// - auto mode when pointers differ
// - auto: reference present dynamic, else static
// - wait 2^23 cycles before static fallback
// - auto mode ignores manual source bit
// - format bit applies only to dynamic mode
// - 20.12 only when bit clear and dynamic
// - 12.20: upper 12 integer, lower 20 fraction
// - main output follows synth, disable floats it
// - unlocked main output low unless overridden
// - aux output four-way mux
// - aux codes: 01 freq ref, 11 lock
// - lock config sets driver type, polarity
// - unlock shown only while reference runs
// - aux disable floats pin; copy unaligned
// - no runt periods on output changes
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps

`include "rsom_cfg.svh"

module rsom_top
    import rsom_pkg::*;
#(
    parameter int LOSS_WAIT = `RSOM_LOSS_WAIT_CYC
)
(
    // system clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // asynchronous clock and status inputs
    input wire logic ref_clk_i,
    input wire logic freq_ref_clk_i,
    input wire logic synth_clk_i,
    input wire logic freq_ref_present_i,
    input wire logic pll_locked_i,
    input wire logic ref_running_i,
    // digital pll ratio, same clock
    input wire rsom_pkg::rsom_ratio_t dpll_ratio_i,
    // synthesizer control
    output rsom_pkg::rsom_ratio_t frac_n_o,
    output rsom_pkg::rsom_ratio_t dpll_target_o,
    output logic format_20_12_o,
    output logic dynamic_o,
    // output pins
    output logic main_clk_o,
    output logic main_clk_oe_n_o,
    output logic aux_o,
    output logic aux_oe_n_o
);
    import rsom_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic [5:0] async_raw;
    logic [5:0] sync_a;
    logic [5:0] sync_b;

    assign async_raw = {ref_running_i, pll_locked_i, freq_ref_present_i,
                        synth_clk_i, freq_ref_clk_i, ref_clk_i};

    // every pin-side signal passes two flops before use
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_sync
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end
                else
                begin
                    sync_a[gi] <= async_raw[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    logic ref_s;
    logic freq_ref_s;
    logic synth_s;
    logic present_s;
    logic locked_s;
    logic ref_run_s;

    assign ref_s = sync_b[0];
    assign freq_ref_s = sync_b[1];
    assign synth_s = sync_b[2];
    assign present_s = sync_b[3];
    assign locked_s = sync_b[4];
    assign ref_run_s = sync_b[5];

    ////////////////////////////////////////////////////////////////////
    // register file and wishbone slave

    rsom_ratio_t user_ratio [4];
    logic [10:0] cfg1;
    logic [5:0] cfg2;
    logic ack;
    logic [31:0] rdata;
    rsom_ratio_t next_user_ratio [4];
    logic [10:0] next_cfg1;
    logic [5:0] next_cfg2;
    logic next_ack;
    logic [31:0] next_rdata;
    logic [31:0] status;
    logic wr_go;

    // write lands on the edge where the master sees ack
    assign wr_go = cyc_i & stb_i & we_i & ack;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return res;
    endfunction

    logic [31:0] cfg1_w;
    logic [31:0] cfg2_w;

    always_comb
    begin
        next_user_ratio = user_ratio;
        next_cfg1 = cfg1;
        next_cfg2 = cfg2;
        cfg1_w = merge({21'h0, cfg1}, dat_i, sel_i);
        cfg2_w = merge({26'h0, cfg2}, dat_i, sel_i);
        next_ack = cyc_i & stb_i & ~ack;
        next_rdata = 32'h0;
        // stored ratios change only by software writes
        if (wr_go)
        begin
            case (adr_i)
                `RSOM_OFS_RATIO0: next_user_ratio[0] = merge(user_ratio[0], dat_i, sel_i);
                `RSOM_OFS_RATIO1: next_user_ratio[1] = merge(user_ratio[1], dat_i, sel_i);
                `RSOM_OFS_RATIO2: next_user_ratio[2] = merge(user_ratio[2], dat_i, sel_i);
                `RSOM_OFS_RATIO3: next_user_ratio[3] = merge(user_ratio[3], dat_i, sel_i);
                `RSOM_OFS_CFG1: next_cfg1 = cfg1_w[10:0];
                `RSOM_OFS_CFG2: next_cfg2 = cfg2_w[5:0];
                default: next_cfg1 = cfg1;
            endcase
        end
        // unmapped addresses read zero and still acknowledge
        case (adr_i)
            `RSOM_OFS_RATIO0: next_rdata = user_ratio[0];
            `RSOM_OFS_RATIO1: next_rdata = user_ratio[1];
            `RSOM_OFS_RATIO2: next_rdata = user_ratio[2];
            `RSOM_OFS_RATIO3: next_rdata = user_ratio[3];
            `RSOM_OFS_CFG1: next_rdata = {21'h0, cfg1};
            `RSOM_OFS_CFG2: next_rdata = {26'h0, cfg2};
            `RSOM_OFS_STATUS: next_rdata = status;
            default: next_rdata = 32'h0;
        endcase
    end

    // fields live in system clock flops, so selection never sees a bus skew
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < 4; i++)
            begin
                user_ratio[i] <= `RSOM_RATIO_RST;
            end
            cfg1 <= `RSOM_CFG1_RST;
            cfg2 <= `RSOM_CFG2_RST;
            ack <= 1'b0;
            rdata <= 32'h0;
        end
        else
        begin
            user_ratio <= next_user_ratio;
            cfg1 <= next_cfg1;
            cfg2 <= next_cfg2;
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    assign ack_o = ack;
    assign dat_o = rdata;

    ////////////////////////////////////////////////////////////////////
    // field decode

    logic [1:0] static_ptr;
    logic [1:0] lock_ptr;
    logic [2:0] mod_sel;
    logic [1:0] ref_div;
    logic auto_mode;

    assign static_ptr = cfg1[`RSOM_C1_STATIC_PTR];
    assign lock_ptr = cfg2[`RSOM_C2_LOCK_PTR];
    assign mod_sel = cfg1[`RSOM_C1_MOD_SEL];
    assign ref_div = cfg1[`RSOM_C1_REF_DIV];
    // software keeps pointers equal for manual use; differing means auto
    assign auto_mode = (lock_ptr != static_ptr);

    ////////////////////////////////////////////////////////////////////
    // source selection with loss wait

    rsom_src_t src;
    logic [23:0] loss_cnt;
    rsom_src_t next_src;
    logic [23:0] next_loss_cnt;

    always_comb
    begin
        next_src = src;
        next_loss_cnt = 24'h0;
        if (!auto_mode)
        begin
            // manual bit is honoured only outside auto mode
            next_src = cfg2[`RSOM_C2_MAN_SRC] ? RSOM_SRC_DYNAMIC : RSOM_SRC_STATIC;
        end
        else
        begin
            case (src)
                RSOM_SRC_STATIC:
                begin
                    if (present_s)
                    begin
                        next_src = RSOM_SRC_DYNAMIC;
                    end
                end
                RSOM_SRC_DYNAMIC:
                begin
                    if (!present_s)
                    begin
                        next_loss_cnt = loss_cnt + 24'h1;
                        if (loss_cnt == 24'(LOSS_WAIT - 1))
                        begin
                            next_src = RSOM_SRC_STATIC;
                            next_loss_cnt = 24'h0;
                        end
                    end
                end
                default: next_src = RSOM_SRC_STATIC;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            src <= RSOM_SRC_STATIC;
            loss_cnt <= 24'h0;
        end
        else
        begin
            src <= next_src;
            loss_cnt <= next_loss_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // effective ratio and fractional-n value

    logic dyn;
    logic [1:0] ptr;
    rsom_ratio_t sel_ratio;
    rsom_ratio_t eff_ratio;
    rsom_ratio_t next_frac_n;
    rsom_ratio_t next_target;
    logic next_fmt;
    rsom_ratio_t frac_n;
    rsom_ratio_t target;
    logic fmt;
    logic dyn_q;

    assign dyn = (src == RSOM_SRC_DYNAMIC);

    always_comb
    begin
        // lock pointer takes over only while auto mode runs dynamic
        ptr = (auto_mode && dyn) ? lock_ptr : static_ptr;
        sel_ratio = user_ratio[ptr];
        // no bypass: code 000 is simply a shift of zero
        if (mod_sel < `RSOM_MOD_DIV_CODE)
        begin
            eff_ratio = sel_ratio << mod_sel[1:0];
        end
        else
        begin
            // widened first so code 111 shifts by four instead of wrapping to zero
            eff_ratio = sel_ratio >> (3'(mod_sel[1:0]) + 3'h1);
        end
        // divider compensation; overflow is left to software
        eff_ratio = eff_ratio << ref_div;
        next_target = eff_ratio;
        next_frac_n = dyn ? dpll_ratio_i : eff_ratio;
        // 12.20 keeps 12 integer bits over 20 fraction bits
        next_fmt = dyn & ~cfg2[`RSOM_C2_LF_FMT];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            frac_n <= 32'h0;
            target <= 32'h0;
            fmt <= 1'b0;
            dyn_q <= 1'b0;
        end
        else
        begin
            frac_n <= next_frac_n;
            target <= next_target;
            fmt <= next_fmt;
            dyn_q <= dyn;
        end
    end

    assign frac_n_o = frac_n;
    assign dpll_target_o = target;
    assign format_20_12_o = fmt;
    assign dynamic_o = dyn_q;

    ////////////////////////////////////////////////////////////////////
    // lock indicator and output stages

    logic unlock_ind;
    logic lock_level;
    logic main_gate;
    logic aux_is_lock;
    logic lock_od;
    logic [3:0] aux_src;
    logic aux_drive;

    // unlock can only be seen while the reference runs
    assign unlock_ind = ~locked_s & ref_run_s;
    assign lock_od = cfg2[`RSOM_C2_LOCK_CFG];
    // open-drain mode pulls low on unlock, push-pull drives high on lock
    assign lock_level = lock_od ? 1'b0 : ~unlock_ind;
    assign aux_is_lock = (cfg1[`RSOM_C1_AUX_SRC] == RSOM_AUX_LOCK);
    assign aux_src = {lock_level, synth_s, freq_ref_s, ref_s};
    assign aux_drive = ~cfg1[`RSOM_C1_AUX_DIS]
                       & ~(aux_is_lock & lock_od & ~unlock_ind);
    // held low while unlocked unless the override is set
    assign main_gate = locked_s | cfg2[`RSOM_C2_ON_UNLOCK];

    rsom_out_stage u_main
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .src_i({3'h0, synth_s}),
        .sel_i(2'h0),
        .gate_i(main_gate),
        .drive_i(~cfg1[`RSOM_C1_MAIN_DIS]),
        .pin_o(main_clk_o),
        .pin_oe_n_o(main_clk_oe_n_o)
    );

    // four-way aux mux; its copy of the synth clock may differ in phase from the main pin
    rsom_out_stage u_aux
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .src_i(aux_src),
        .sel_i(cfg1[`RSOM_C1_AUX_SRC]),
        .gate_i(1'b1),
        .drive_i(aux_drive),
        .pin_o(aux_o),
        .pin_oe_n_o(aux_oe_n_o)
    );

    // status word: live source state and inputs
    assign status = {24'h0, fmt, unlock_ind, ref_run_s, locked_s,
                     present_s, auto_mode, dyn, 1'b0};

endmodule

//--- design/rsom_cfg.svh
// offsets, field positions, reset values and timing counts for ratio select and output mux
`ifndef RSOM_CFG_SVH
`define RSOM_CFG_SVH

// register byte offsets on the bus
`define RSOM_OFS_RATIO0 5'h00
`define RSOM_OFS_RATIO1 5'h04
`define RSOM_OFS_RATIO2 5'h08
`define RSOM_OFS_RATIO3 5'h0c
`define RSOM_OFS_CFG1 5'h10
`define RSOM_OFS_CFG2 5'h14
`define RSOM_OFS_STATUS 5'h18

// configuration 1 field positions
`define RSOM_C1_STATIC_PTR 1:0
`define RSOM_C1_MOD_SEL 4:2
`define RSOM_C1_AUX_SRC 6:5
`define RSOM_C1_MAIN_DIS 7
`define RSOM_C1_AUX_DIS 8
`define RSOM_C1_REF_DIV 10:9

// configuration 2 field positions
`define RSOM_C2_LOCK_PTR 1:0
`define RSOM_C2_MAN_SRC 2
`define RSOM_C2_LF_FMT 3
`define RSOM_C2_ON_UNLOCK 4
`define RSOM_C2_LOCK_CFG 5

// reset values
`define RSOM_CFG1_RST 11'h000
`define RSOM_CFG2_RST 6'h00
`define RSOM_RATIO_RST 32'h0000_0000

// modifier shift boundary: codes at or above this divide
`define RSOM_MOD_DIV_CODE 3'h4

// wait after losing the frequency reference, in system clock cycles
`define RSOM_LOSS_WAIT_CYC 8388608

`endif

//--- design/rsom_pkg.sv
// types shared by the ratio select and output mux block
package rsom_pkg;

    // fractional-n source state, one-hot
    typedef enum logic [1:0]
    {
        RSOM_SRC_STATIC = 2'b01,
        RSOM_SRC_DYNAMIC = 2'b10
    } rsom_src_t;

    // auxiliary output sources
    typedef enum logic [1:0]
    {
        RSOM_AUX_REF = 2'b00,
        RSOM_AUX_FREQ_REF = 2'b01,
        RSOM_AUX_PLL = 2'b10,
        RSOM_AUX_LOCK = 2'b11
    } rsom_aux_t;

    typedef logic [31:0] rsom_ratio_t;

endpackage

//--- design/rsom_out_stage.sv
// glitch-free output stage: switches source or enable only in a low phase
`timescale 1ns/1ps

module rsom_out_stage
    import rsom_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // sampled sources and control
    input wire logic [3:0] src_i,
    input wire logic [1:0] sel_i,
    input wire logic gate_i,
    input wire logic drive_i,
    // pin
    output logic pin_o,
    output logic pin_oe_n_o
);
    import rsom_pkg::*;

    logic [1:0] sel;
    logic gate;
    logic drive;
    logic pin;
    logic [1:0] next_sel;
    logic next_gate;
    logic next_drive;
    logic next_pin;

    // take new settings only while the pin is low and the new source is low,
    // so no shortened high phase can appear
    always_comb
    begin
        next_sel = sel;
        next_gate = gate;
        next_drive = drive;
        if (!pin && !src_i[sel_i])
        begin
            next_sel = sel_i;
            next_gate = gate_i;
            next_drive = drive_i;
        end
        next_pin = next_gate & src_i[next_sel];
    end

    // registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sel <= 2'h0;
            gate <= 1'b0;
            drive <= 1'b0;
            pin <= 1'b0;
        end
        else
        begin
            sel <= next_sel;
            gate <= next_gate;
            drive <= next_drive;
            pin <= next_pin;
        end
    end

    assign pin_o = pin;
    assign pin_oe_n_o = ~drive;

endmodule

//--- tb/rsom_props.sv
// port-level assertions for the ratio select and output mux block
`timescale 1ns/1ps
module rsom_props
    import rsom_pkg::*;
(
    // clock, reset and bus handshake
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    // ratio path
    input wire rsom_pkg::rsom_ratio_t dpll_ratio_i,
    input wire rsom_pkg::rsom_ratio_t frac_n_o,
    input wire rsom_pkg::rsom_ratio_t dpll_target_o,
    input wire logic format_20_12_o,
    input wire logic dynamic_o,
    // pins
    input wire logic main_clk_o,
    input wire logic main_clk_oe_n_o,
    input wire logic aux_o,
    input wire logic aux_oe_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////////////
    // bus steps: a fresh request, then exactly one ack pulse
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_answer;
        ack_o ##1 !ack_o;
    endsequence
    a_ack_one_pulse: assert property (s_req |=> s_answer) else $error("ack not a single pulse");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o && main_clk_oe_n_o
        && aux_oe_n_o && !dynamic_o) else $error("outputs active in reset");

    ////////////////////////////////////////////////////////////////////////////////
    // source selection; the ratio checks run only once the source has settled a cycle
    a_dyn_follow: assert property (dynamic_o && $past(dynamic_o) |->
        frac_n_o == $past(dpll_ratio_i)) else $error("dynamic source not followed");
    a_static_eff: assert property (!dynamic_o && !$past(dynamic_o) && !$past(rst_i) |->
        frac_n_o == dpll_target_o) else $error("static source not effective ratio");
    a_wide_fmt_dyn: assert property ($rose(format_20_12_o) |-> dynamic_o)
        else $error("wide format outside dynamic mode");

    ////////////////////////////////////////////////////////////////////////////////
    // pins change drive only in a low phase, so no runt period appears
    a_main_start_low: assert property ($fell(main_clk_oe_n_o) |-> !main_clk_o)
        else $error("main pin enabled high");
    a_main_stop_low: assert property ($rose(main_clk_oe_n_o) |-> !$past(main_clk_o))
        else $error("main pin released high");
    a_aux_start_low: assert property ($fell(aux_oe_n_o) |-> !aux_o)
        else $error("aux pin enabled high");
endmodule

//--- tb/rsom_clk_model.sv
// clock and presence sources at the far side: reference, frequency reference, synthesizer
`timescale 1ns/1ps
module rsom_clk_model
(
    // source controls from the bench
    input wire logic freq_on_i,
    input wire logic ref_on_i,
    // clocks and status levels
    output logic ref_clk_o,
    output logic freq_ref_clk_o,
    output logic synth_clk_o,
    output logic freq_present_o,
    output logic ref_running_o
);
    logic rc = 1'h0;
    logic fc = 1'h0;
    logic sc = 1'h0;
    // free phases unrelated to the system clock
    always #35 rc = ~rc;
    always #65 fc = ~fc;
    always #25 sc = ~sc;
    // a stopped source stands still low rather than holding its last level
    assign ref_clk_o = rc & ref_on_i;
    assign freq_ref_clk_o = fc & freq_on_i;
    assign synth_clk_o = sc;
    assign freq_present_o = freq_on_i;
    assign ref_running_o = ref_on_i;
endmodule

//--- tb/ratio_select_and_output_mux_test.sv
// self-checking bench for the ratio select and output mux block
`timescale 1ns/1ps
module ratio_select_and_output_mux_test;
    import rsom_pkg::*;
    localparam int LW = 16;
    logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
    logic [4:0] adr_i = 5'h00;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0, dat_o, q, r [4];
    logic ack_o, freq_on = 1'h1, ref_on = 1'h1, pll_locked_i = 1'h1;
    logic ref_clk_i, freq_ref_clk_i, synth_clk_i, freq_ref_present_i, ref_running_i;
    rsom_ratio_t dpll_ratio_i = 32'h0, frac_n_o, dpll_target_o;
    logic format_20_12_o, dynamic_o, main_clk_o, main_clk_oe_n_o, aux_o, aux_oe_n_o;
    int failures = 0, checks_done = 0, hm, ha;

    // system clock, 100 MHz
    always #5 clk_i = ~clk_i;

    rsom_top #(.LOSS_WAIT(LW)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .ref_clk_i(ref_clk_i), .freq_ref_clk_i(freq_ref_clk_i),
        .synth_clk_i(synth_clk_i), .freq_ref_present_i(freq_ref_present_i),
        .pll_locked_i(pll_locked_i), .ref_running_i(ref_running_i),
        .dpll_ratio_i(dpll_ratio_i), .frac_n_o(frac_n_o), .dpll_target_o(dpll_target_o),
        .format_20_12_o(format_20_12_o), .dynamic_o(dynamic_o), .main_clk_o(main_clk_o),
        .main_clk_oe_n_o(main_clk_oe_n_o), .aux_o(aux_o), .aux_oe_n_o(aux_oe_n_o));
    rsom_clk_model SRC (.freq_on_i(freq_on), .ref_on_i(ref_on), .ref_clk_o(ref_clk_i),
        .freq_ref_clk_o(freq_ref_clk_i), .synth_clk_o(synth_clk_i),
        .freq_present_o(freq_ref_present_i), .ref_running_o(ref_running_i));

    ////////////////////////////////////////////////////////////////////////////////
    // expected effective ratio: modifier shift, then divider compensation
    function automatic logic [31:0] eff(logic [31:0] u, int m, int d);
        logic [31:0] v;
        v = (m < 4) ? u << m : u >> (m - 3);
        return v << d;
    endfunction
    task automatic give_verdict();
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // classic single cycle; ack is sampled at the edge, before its own update lands
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
        output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'h1 && n < 20);
        if (n >= 20)
        begin
            failures++;
            give_verdict();
        end
        rd = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
    endtask
    // counts high samples of both pins over a window longer than any source period
    task automatic cnt();
        hm = 0;
        ha = 0;
        repeat (40)
        begin
            @(posedge clk_i);
            hm += (main_clk_o === 1'h1);
            ha += (aux_o === 1'h1);
        end
    endtask

    // hang guard
    initial
    begin
        wt(90000);
        failures++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        q = $urandom(65);
        wt(6);
        rst_i <= 1'h0;
        wb(1'h0, 5'h10, 32'h0, q);
        check("cfg1 reset", q, 32'h0);
        wb(1'h0, 5'h1c, 32'h0, q);
        check("unmapped", q, 32'h0);
        // ratios kept small so no modifier overflows
        for (int i = 0; i < 4; i++)
        begin
            r[i] = $urandom & 32'h000f_ffff;
            wb(1'h1, 5'(i * 4), r[i], q);
        end
        // every modifier code, each with divider code and pointer set to the code mod 4
        for (int i = 0; i < 8; i++)
        begin
            wb(1'h1, 5'h14, 32'(i % 4), q);
            wb(1'h1, 5'h10, 32'((i % 4) << 9 | i << 2 | i % 4), q);
            wt(8);
            check("target", dpll_target_o, eff(r[i % 4], i, i % 4));
            check("static frac", frac_n_o, eff(r[i % 4], i, i % 4));
            check("static", dynamic_o, 1'h0);
        end
        for (int i = 0; i < 4; i++)
        begin
            wb(1'h0, 5'(i * 4), 32'h0, q);
            check("stored", q, r[i]);
        end
        // manual dynamic source in both formats
        dpll_ratio_i <= $urandom;
        wb(1'h1, 5'h10, 32'h0, q);
        wb(1'h1, 5'h14, 32'h4, q);
        wt(8);
        check("dyn", dynamic_o, 1'h1);
        check("dyn frac", frac_n_o, dpll_ratio_i);
        check("fmt wide", format_20_12_o, 1'h1);
        wb(1'h1, 5'h14, 32'hc, q);
        wt(8);
        check("fmt fine", format_20_12_o, 1'h0);
        wb(1'h1, 5'h14, 32'h0, q);
        wt(8);
        check("fmt static", format_20_12_o, 1'h0);
        // automatic mode, manual bit left clear, then loss of the reference
        wb(1'h1, 5'h14, 32'h1, q);
        wt(8);
        check("auto dyn", dynamic_o, 1'h1);
        check("auto target", dpll_target_o, r[1]);
        freq_on <= 1'h0;
        wt(LW);
        check("loss wait", dynamic_o, 1'h1);
        wt(8);
        check("fallback", dynamic_o, 1'h0);
        check("fallback target", dpll_target_o, r[0]);
        check("fallback fmt", format_20_12_o, 1'h0);
        freq_on <= 1'h1;
        // main pin: runs, gated on unlock, override, disable
        wb(1'h1, 5'h14, 32'h0, q);
        cnt();
        check("main on", hm > 0, 1'h1);
        check("main oe", main_clk_oe_n_o, 1'h0);
        pll_locked_i <= 1'h0;
        wt(12);
        cnt();
        check("main unlock", hm, 32'h0);
        wb(1'h1, 5'h14, 32'h10, q);
        cnt();
        check("main override", hm > 0, 1'h1);
        wb(1'h1, 5'h10, 32'h80, q);
        wt(12);
        check("main off", main_clk_oe_n_o, 1'h1);
        // aux clock sources, then the frequency reference stopped
        for (int i = 0; i < 3; i++)
        begin
            wb(1'h1, 5'h10, 32'(i << 5), q);
            cnt();
            check("aux runs", ha > 0, 1'h1);
        end
        freq_on <= 1'h0;
        wb(1'h1, 5'h10, 32'h20, q);
        cnt();
        check("aux freq off", ha, 32'h0);
        // lock indicator, push-pull then open drain
        wb(1'h1, 5'h10, 32'h60, q);
        wt(12);
        check("aux unlock", aux_o, 1'h0);
        pll_locked_i <= 1'h1;
        wt(12);
        check("aux lock", aux_o, 1'h1);
        pll_locked_i <= 1'h0;
        ref_on <= 1'h0;
        wt(12);
        check("no ref", aux_o, 1'h1);
        ref_on <= 1'h1;
        wb(1'h1, 5'h14, 32'h30, q);
        wt(12);
        check("od low", {aux_oe_n_o, aux_o}, 2'h0);
        pll_locked_i <= 1'h1;
        wt(12);
        check("od float", aux_oe_n_o, 1'h1);
        wb(1'h1, 5'h10, 32'h0, q);
        wb(1'h1, 5'h14, 32'h0, q);
        wt(12);
        check("aux on", aux_oe_n_o, 1'h0);
        wb(1'h1, 5'h10, 32'h100, q);
        wt(12);
        check("aux off", aux_oe_n_o, 1'h1);
        give_verdict();
    end
endmodule

bind rsom_top rsom_props u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .dpll_ratio_i(dpll_ratio_i), .frac_n_o(frac_n_o),
    .dpll_target_o(dpll_target_o), .format_20_12_o(format_20_12_o), .dynamic_o(dynamic_o),
    .main_clk_o(main_clk_o), .main_clk_oe_n_o(main_clk_oe_n_o), .aux_o(aux_o),
    .aux_oe_n_o(aux_oe_n_o));
